// ---- common/amito_pkg.sv ----
// Purpose: constants and types for the alert mask and on-chip temperature offset block
// Assumes: 8-bit register bus behind the serial management engine
// Notes: status and mask vectors share one 24-bit layout
package amito_pkg;
   localparam int REG_W = 8;
   localparam int VEC_W = 24;
   // register offsets
   localparam logic [7:0] OFS_MASK_MISC = 8'h1b;
   localparam logic [7:0] OFS_MASK_IO_LOW = 8'h1c;
   localparam logic [7:0] OFS_MASK_IO_HIGH = 8'h1d;
   localparam logic [7:0] OFS_TEMP_OFFSET = 8'h1e;
   localparam logic [7:0] OFS_TEMP_RESULT = 8'h1f;
   // reset values
   localparam logic [7:0] RST_MASK_MISC = 8'h00;
   localparam logic [7:0] RST_MASK_IO_LOW = 8'h00;
   localparam logic [7:0] RST_MASK_IO_HIGH = 8'h00;
   localparam logic [7:0] RST_TEMP_OFFSET = 8'h00;
   localparam logic [7:0] RST_TEMP_RESULT = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // bit positions within the misc mask and within the shared vector
   localparam int BIT_ONCHIP_TEMP = 0;
   localparam int BIT_BATTERY = 1;
   localparam int BIT_ANALOG_INPUT_8 = 2;
   localparam int BIT_THERMAL_LIMIT_EVENT = 3;
   localparam int BIT_AUTOMATIC_FAN_CONTROL = 4;
   localparam int BIT_UNUSED = 5;
   localparam int BIT_CHASSIS_INTRUSION = 6;
   localparam int BIT_GENERAL_IO_16 = 7;
   localparam int IO_LOW_LSB = 8;
   localparam int IO_HIGH_LSB = 16;
   // writable bits of the misc mask; the unused bit is held at zero
   localparam logic [7:0] MISC_WRITE_MASK = 8'hdf;
   // signed saturation bounds of the corrected temperature
   localparam logic signed [8:0] TEMP_MAX = 9'sh07f;
   localparam logic signed [8:0] TEMP_MIN = -9'sh080;

   typedef struct packed {
      logic [7:0] maskMisc;
      logic [7:0] maskIoLow;
      logic [7:0] maskIoHigh;
      logic [7:0] tempOffset;
      logic [7:0] tempResult;
      logic tempStatus;
      logic [7:0] rdData;
      logic rdValid;
      logic [23:0] statusView;
      logic alert;
   } amito_state_type;
endpackage

// ---- common/amito_gate_if.sv ----
// Purpose: carries the status and mask vectors to the gating logic
// Assumes: one bit per interrupt source in the shared layout
// Notes: purely combinational signals
`timescale 1ns/1ps
interface amito_gate_if;
   logic [23:0] status;
   logic [23:0] mask;
   logic [23:0] pending;
   logic anyPending;
   modport ctrl (output status, output mask, input pending, input anyPending);
   modport gate (input status, input mask, output pending, output anyPending);
endinterface

// ---- hdl/amito_status_gate.sv ----
// Purpose: masks each source's status and folds them into one request
// Assumes: a set mask bit suppresses its source
// Notes: status itself is passed on untouched elsewhere
`timescale 1ns/1ps
module amito_status_gate
(
   amito_gate_if.gate gp
);
   genvar i;
   generate
      for (i = 0; i < amito_pkg::VEC_W; i = i + 1)
      begin : gen_gate
         // masked source contributes nothing
         assign gp.pending[i] = gp.status[i] & ~gp.mask[i];
      end
   endgenerate
   assign gp.anyPending = |gp.pending;
endmodule

// ---- hdl/amito_top.sv ----
// Purpose: alert mask registers, on-chip temperature offset and result, alert output
// Assumes: register strobes come from the serial bus engine, one cycle each
// Notes: other sources' status levels arrive from their own comparators
`timescale 1ns/1ps
module amito_top
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic convValid,
   input wire logic [7:0] convRaw,
   input wire logic [7:0] tempHighLimit,
   input wire logic [7:0] tempLowLimit,
   input wire logic batteryStatus,
   input wire logic analogInput8Status,
   input wire logic thermalLimitEventStatus,
   input wire logic automaticFanControlStatus,
   input wire logic chassisIntrusionStatus,
   input wire logic [16:0] generalIoStatus,
   output logic [23:0] statusView,
   output logic [7:0] tempResult,
   output logic onchipTempStatus,
   output logic alertInt
);
   amito_pkg::amito_state_type st_r;
   amito_pkg::amito_state_type st_nxt;
   amito_gate_if gateBus ();

   logic signed [8:0] tempSum;
   logic [7:0] tempCorr;
   logic tempAbove;
   logic tempBelow;
   logic tempOut;
   logic [23:0] maskVec;
   logic [23:0] statusNow;
   logic [7:0] readMux;

   function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] ofs);
      hitReg = (addr == ofs);
   endfunction

   // signed offset applied to the raw conversion, saturated
   always_comb
   begin
      tempSum = $signed({convRaw[7], convRaw}) + $signed({st_r.tempOffset[7], st_r.tempOffset});
      if (tempSum > amito_pkg::TEMP_MAX)
      begin
         tempCorr = amito_pkg::TEMP_MAX[7:0];
      end
      else if (tempSum < amito_pkg::TEMP_MIN)
      begin
         tempCorr = amito_pkg::TEMP_MIN[7:0];
      end
      else
      begin
         tempCorr = tempSum[7:0];
      end
   end

   // limit check on the corrected value
   always_comb
   begin
      tempAbove = $signed(tempCorr) > $signed(tempHighLimit);
      tempBelow = $signed(tempCorr) < $signed(tempLowLimit);
      tempOut = tempAbove || tempBelow;
   end

   // assemble status in the mask layout
   always_comb
   begin
      statusNow = '0;
      statusNow[amito_pkg::BIT_ONCHIP_TEMP] = st_r.tempStatus;
      statusNow[amito_pkg::BIT_BATTERY] = batteryStatus;
      statusNow[amito_pkg::BIT_ANALOG_INPUT_8] = analogInput8Status;
      statusNow[amito_pkg::BIT_THERMAL_LIMIT_EVENT] = thermalLimitEventStatus;
      statusNow[amito_pkg::BIT_AUTOMATIC_FAN_CONTROL] = automaticFanControlStatus;
      statusNow[amito_pkg::BIT_UNUSED] = 1'b0;
      statusNow[amito_pkg::BIT_CHASSIS_INTRUSION] = chassisIntrusionStatus;
      statusNow[amito_pkg::BIT_GENERAL_IO_16] = generalIoStatus[16];
      statusNow[amito_pkg::IO_LOW_LSB +: 8] = generalIoStatus[7:0];
      statusNow[amito_pkg::IO_HIGH_LSB +: 8] = generalIoStatus[15:8];
   end

   assign gateBus.status = statusNow;
   // mask vector in the status layout
   always_comb
   begin
      maskVec = '0;
      maskVec[amito_pkg::BIT_ONCHIP_TEMP +: amito_pkg::REG_W] = st_r.maskMisc;
      maskVec[amito_pkg::IO_LOW_LSB +: amito_pkg::REG_W] = st_r.maskIoLow;
      maskVec[amito_pkg::IO_HIGH_LSB +: amito_pkg::REG_W] = st_r.maskIoHigh;
   end

   assign gateBus.mask = maskVec;

   amito_status_gate u_gate
   (
      .gp(gateBus)
   );

   // register read selection
   always_comb
   begin
      readMux = amito_pkg::UNMAPPED_DATA;
      if (hitReg(regAddr, amito_pkg::OFS_MASK_MISC))
      begin
         readMux = st_r.maskMisc & amito_pkg::MISC_WRITE_MASK;
      end
      else if (hitReg(regAddr, amito_pkg::OFS_MASK_IO_LOW))
      begin
         readMux = st_r.maskIoLow;
      end
      else if (hitReg(regAddr, amito_pkg::OFS_MASK_IO_HIGH))
      begin
         readMux = st_r.maskIoHigh;
      end
      else if (hitReg(regAddr, amito_pkg::OFS_TEMP_OFFSET))
      begin
         readMux = st_r.tempOffset;
      end
      else if (hitReg(regAddr, amito_pkg::OFS_TEMP_RESULT))
      begin
         readMux = st_r.tempResult;
      end
      else
      begin
         readMux = amito_pkg::UNMAPPED_DATA;
      end
   end

   // next state
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdValid = 1'b0;
      if (regWrEn)
      begin
         if (hitReg(regAddr, amito_pkg::OFS_MASK_MISC))
         begin
            st_nxt.maskMisc = regWrData & amito_pkg::MISC_WRITE_MASK;
         end
         if (hitReg(regAddr, amito_pkg::OFS_MASK_IO_LOW))
         begin
            st_nxt.maskIoLow = regWrData;
         end
         if (hitReg(regAddr, amito_pkg::OFS_MASK_IO_HIGH))
         begin
            st_nxt.maskIoHigh = regWrData;
         end
         if (hitReg(regAddr, amito_pkg::OFS_TEMP_OFFSET))
         begin
            st_nxt.tempOffset = regWrData;
         end
         // result register has no write path
      end
      // read sees the value before a same-cycle write
      if (regRdEn)
      begin
         st_nxt.rdData = readMux;
         st_nxt.rdValid = 1'b1;
      end
      // each conversion stores the corrected value and its limit status
      if (convValid)
      begin
         st_nxt.tempResult = tempCorr;
         st_nxt.tempStatus = tempOut;
      end
      // status kept regardless of mask
      st_nxt.statusView = statusNow;
      st_nxt.alert = gateBus.anyPending;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_r.maskMisc <= amito_pkg::RST_MASK_MISC;
         st_r.maskIoLow <= amito_pkg::RST_MASK_IO_LOW;
         st_r.maskIoHigh <= amito_pkg::RST_MASK_IO_HIGH;
         st_r.tempOffset <= amito_pkg::RST_TEMP_OFFSET;
         st_r.tempResult <= amito_pkg::RST_TEMP_RESULT;
         st_r.tempStatus <= 1'b0;
         st_r.rdData <= amito_pkg::RST_READ_DATA;
         st_r.rdValid <= 1'b0;
         st_r.statusView <= '0;
         st_r.alert <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign regRdData = st_r.rdData;
   assign regRdValid = st_r.rdValid;
   assign statusView = st_r.statusView;
   assign tempResult = st_r.tempResult;
   assign onchipTempStatus = st_r.tempStatus;
   assign alertInt = st_r.alert;
endmodule

// ---- sim/amito_host_model.sv ----
// Purpose: register bus host for amito_top
// Assumes: read answer one cycle after the strobe
// Notes: drives 1 ns after rising edges
`timescale 1ns/1ps
module amito_host_model
(
   input wire logic clk,
   output logic [7:0] regAddr,
   output logic regWrEn,
   output logic [7:0] regWrData,
   output logic regRdEn,
   input wire logic [7:0] regRdData
);
   initial
   begin
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
      regRdEn = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge clk);
      #1;
      regWrEn = 1'b0;
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge clk);
      #1;
      regRdEn = 1'b0;
      d = regRdData;
   endtask
endmodule

// ---- sim/amito_sva.sv ----
// Purpose: port checks for amito_top
// Assumes: one clock, synchronous reset
// Notes: bound at the foot
`timescale 1ns/1ps
module amito_sva
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] regAddr,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic convValid,
   input wire logic [7:0] tempHighLimit,
   input wire logic [7:0] tempLowLimit,
   input wire logic batteryStatus,
   input wire logic [16:0] generalIoStatus,
   input wire logic [23:0] statusView,
   input wire logic [7:0] tempResult,
   input wire logic onchipTempStatus,
   input wire logic alertInt
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_miscRd;
      regRdEn && regAddr == 8'h1b ##1 regRdValid;
   endsequence
   sequence s_resultRd;
      regRdEn && regAddr == 8'h1f ##1 regRdValid;
   endsequence
   AST_BIT5: assert property (s_miscRd |-> !regRdData[5]) else $error("bit 5 read");
   AST_RESRD: assert property (s_resultRd |-> regRdData == $past(tempResult)) else $error("result read");
   AST_RDV: assert property (regRdEn |=> regRdValid) else $error("no valid");
   AST_NORD: assert property (!regRdEn |=> !regRdValid) else $error("stray valid");
   AST_ALERT: assert property (alertInt |-> statusView != 24'h0) else $error("alert");
   AST_SV5: assert property (statusView[5] == 1'b0) else $error("sv5");
   AST_BAT: assert property ($past(rst_b) |-> statusView[1] == $past(batteryStatus)) else $error("bat");
   AST_IO: assert property ($past(rst_b) |-> statusView[23:8] == $past(generalIoStatus[15:0])
      && statusView[7] == $past(generalIoStatus[16])) else $error("io");
   AST_T0: assert property ($past(rst_b) |-> statusView[0] == $past(onchipTempStatus)) else $error("t0");
   AST_LIM: assert property (convValid |=> onchipTempStatus == ($signed(tempResult) > $signed(tempHighLimit)
      || $signed(tempResult) < $signed(tempLowLimit))) else $error("limit");
   AST_HOLD: assert property (!convValid |=> $stable(tempResult)) else $error("result moved");
   AST_RST: assert property (disable iff (1'b0) !rst_b |=> !alertInt && tempResult == 8'h00
      && statusView == 24'h0) else $error("reset");
endmodule
bind amito_top amito_sva u_sva (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regRdEn(regRdEn),
   .regRdData(regRdData), .regRdValid(regRdValid), .convValid(convValid), .tempHighLimit(tempHighLimit),
   .tempLowLimit(tempLowLimit), .batteryStatus(batteryStatus), .generalIoStatus(generalIoStatus),
   .statusView(statusView), .tempResult(tempResult), .onchipTempStatus(onchipTempStatus), .alertInt(alertInt));

// ---- sim/tb_alert_mask_and_int_temp_offset.sv ----
// Purpose: register and mask tests for amito_top
// Assumes: host model drives the register bus
// Notes: src holds status sources in the statusView layout
`timescale 1ns/1ps
module tb_alert_mask_and_int_temp_offset;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic convValid = 1'b0;
   logic [7:0] convRaw = 8'h00;
   logic [7:0] hiLim = 8'h7f;
   logic [7:0] loLim = 8'h00;
   logic [23:0] src = 24'h0;
   logic [7:0] regAddr, regWrData, regRdData, tempResult, rdv;
   logic regWrEn, regRdEn, regRdValid, onchipTempStatus, alertInt;
   logic [23:0] statusView;
   int nFail = 0;
   int totalChecks = 0;
   always #5 clk = ~clk;
   amito_host_model u_host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdEn(regRdEn), .regRdData(regRdData));
   amito_top u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .convValid(convValid),
      .convRaw(convRaw), .tempHighLimit(hiLim), .tempLowLimit(loLim), .batteryStatus(src[1]),
      .analogInput8Status(src[2]), .thermalLimitEventStatus(src[3]), .automaticFanControlStatus(src[4]),
      .chassisIntrusionStatus(src[6]), .generalIoStatus({src[7], src[23:8]}), .statusView(statusView),
      .tempResult(tempResult), .onchipTempStatus(onchipTempStatus), .alertInt(alertInt));
   task automatic chk(input logic [24:0] got, input logic [24:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, rdv);
      chk({17'h0, rdv}, {17'h0, e});
      chk({24'h0, regRdValid}, 25'h1);
   endtask
   task automatic conv(input logic [7:0] raw);
      @(posedge clk);
      #1 convValid = 1'b1;
      convRaw = raw;
      @(posedge clk);
      #1 convValid = 1'b0;
      convRaw = ~raw;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic maskOne(input int i);
      chk({alertInt, statusView}, 25'h0);
      if (i == 0)
         conv(8'h30);
      else
      begin
         src[i] = 1'b1;
         repeat (2) @(posedge clk);
         #1;
      end
      chk({alertInt, statusView}, {1'b1, 24'(1 << i)});
      u_host.wr(8'h1b + 8'(i / 8), 8'(1 << (i % 8)));
      @(posedge clk);
      #1;
      chk({alertInt, statusView}, {1'b0, 24'(1 << i)});
      u_host.wr(8'h1b + 8'(i / 8), 8'h00);
      src = 24'h0;
      conv(8'h00);
   endtask
   task finalReport;
      if (nFail == 0 && totalChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      nFail++;
      finalReport;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int a = 27; a < 32; a++) rdChk(8'(a), 8'h00);
      u_host.wr(8'h1b, 8'hff);
      rdChk(8'h1b, 8'hdf);
      u_host.wr(8'h1c, 8'ha5);
      u_host.wr(8'h1d, 8'h5a);
      rdChk(8'h1c, 8'ha5);
      rdChk(8'h1d, 8'h5a);
      rdChk(8'h20, 8'h00);
      u_host.wr(8'h1e, 8'h05);
      conv(8'h10);
      rdChk(8'h1f, 8'h15);
      u_host.wr(8'h1f, 8'h77);
      rdChk(8'h1f, 8'h15);
      u_host.wr(8'h1e, 8'hfb);
      conv(8'h10);
      chk({16'h0, onchipTempStatus, tempResult}, {16'h0, 1'b0, 8'h0b});
      u_host.wr(8'h1e, 8'h70);
      conv(8'h70);
      chk({16'h0, onchipTempStatus, tempResult}, {16'h0, 1'b0, 8'h7f});
      u_host.wr(8'h1e, 8'h90);
      conv(8'h90);
      chk({16'h0, onchipTempStatus, tempResult}, {16'h0, 1'b1, 8'h80});
      for (int a = 27; a < 31; a++) u_host.wr(8'(a), 8'h00);
      hiLim = 8'h20;
      loLim = 8'hf0;
      conv(8'hf8);
      chk({24'h0, onchipTempStatus}, 25'h0);
      conv(8'he0);
      chk({24'h0, onchipTempStatus}, 25'h1);
      conv(8'h00);
      for (int i = 0; i < 24; i++) if (i != 5) maskOne(i);
      u_host.wr(8'h1c, 8'h3c);
      u_host.wr(8'h1e, 8'h11);
      conv(8'h01);
      rdChk(8'h1f, 8'h12);
      rst_b = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int a = 27; a < 32; a++) rdChk(8'(a), 8'h00);
      finalReport;
   end
endmodule
